// [xfer_branch_defs.svh]
// Opcode patterns, lengths and cycle counts for the decoder
// Assumes an 8-bit opcode fetched by the core sequencer
// Functional notes
// - Accumulator loads: E8-EF 1B/1c, E5 2B/2c, E6-E7 1B/2c, 74 2B/2c
// - Register loads: F8-FF 1B/2c, A8-AF 2B/4c, 78-7F 2B/2c
// - Direct stores: F5, 88-8F 2B/3c; 85 3B/4c; 86-87 2B/4c; 75 3B/3c
// - Indirect stores: F6-F7 1B/3c, A6-A7 2B/5c, 76-77 2B/3c
// - Data pointer immediate load 90, three bytes, three cycles
// - Code byte loads 93 and 83, one byte, three cycles
// - External reads E2-E3, E0: one byte, three to ten cycles
// - External writes F2-F3, F0: one byte, four to eleven cycles
// - External moves pick one of two actions by mode bit
// - Push C0 2B/4c, pop D0 2B/3c
// - Swaps C8-CF 1B/2c, C5 2B/3c, C6-C7 1B/3c; nibble D6-D7 1B/3c
// - Jumps xxx00001 2B/3c, 02 3B/4c, 80 2B/3c, 73 1B/2c
// - Branch 60 taken only when accumulator is zero, 2B/3c
// - Branch 40 on carry set, 50 on carry clear, 2B/3c
// - Bit branches 20, 30, 10 3B/4c; 10 also clears bit
// - Compare branches B5, B4, B8-BF, B6-B7, all 3B/4c
// - Decrement branch D8-DF 2B/3c, D5 3B/4c
// - Bit ops C2 D2 B2 2B/3c; carry forms C3 D3 B3 1B/1c
// - Carry combine 82, B0, 72, A0, each 2B/2c
// - Bit to carry A2 2B/2c; carry to bit 92 2B/3c
`ifndef XFER_BRANCH_DEFS_SVH
`define XFER_BRANCH_DEFS_SVH
`define L1 2'h1
`define L2 2'h2
`define L3 2'h3
`define C1 4'h1
`define C2 4'h2
`define C3 4'h3
`define C4 4'h4
`define C5 4'h5
`define C6 4'h6
`define OP_A_DIR 8'hE5
`define OP_A_IMM 8'h74
`define OP_DIR_A 8'hF5
`define OP_DIR_DIR 8'h85
`define OP_DIR_IMM 8'h75
`define OP_DP_IMM 8'h90
`define OP_CODE_DP 8'h93
`define OP_CODE_PC 8'h83
`define OP_EXT_RD_DP 8'hE0
`define OP_EXT_WR_DP 8'hF0
`define OP_PUSH 8'hC0
`define OP_POP 8'hD0
`define OP_SWAP_DIR 8'hC5
`define OP_FAR_JUMP 8'h02
`define OP_REL_JUMP 8'h80
`define OP_JMP_IND 8'h73
`define OP_BR_ZERO 8'h60
`define OP_BR_NZERO 8'h70
`define OP_BR_CY 8'h40
`define OP_BR_NCY 8'h50
`define OP_BR_BIT 8'h20
`define OP_BR_NBIT 8'h30
`define OP_BR_BIT_CLR 8'h10
`define OP_CMP_DIR 8'hB5
`define OP_CMP_IMM 8'hB4
`define OP_DEC_DIR 8'hD5
`define OP_FAR_CALL 8'h12
`define OP_SUB_EXIT 8'h22
`define OP_INT_EXIT 8'h32
`define OP_CLR_BIT 8'hC2
`define OP_SET_BIT 8'hD2
`define OP_INV_BIT 8'hB2
`define OP_CLR_C 8'hC3
`define OP_SET_C 8'hD3
`define OP_INV_C 8'hB3
`define OP_AND_C 8'h82
`define OP_ANDN_C 8'hB0
`define OP_OR_C 8'h72
`define OP_ORN_C 8'hA0
`define OP_BIT_C 8'hA2
`define OP_C_BIT 8'h92
`define CYC_ZERO 4'h0
`endif

// [xfer_branch_pkg.sv]
// Types shared by the transfer and branch decoder
// Assumes the constants header for all figures
package xfer_branch_pkg;
    typedef enum logic [3:0] {
        CLS_NONE, CLS_XFER, CLS_EXT_RD, CLS_EXT_WR, CLS_CODE_LD, CLS_STACK,
        CLS_SWAP, CLS_JUMP, CLS_CALL, CLS_EXIT, CLS_COND, CLS_BIT
    } class_e;
    typedef enum logic [3:0] {
        CND_NONE, CND_ACC_Z, CND_ACC_NZ, CND_CY, CND_NCY,
        CND_BIT, CND_NBIT, CND_UNEQ, CND_DEC_NZ
    } cond_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;
    // Static decode of one opcode
    typedef struct packed {
        class_e cls;
        cond_e cond;
        logic [1:0] len;
        logic [3:0] cyc;
        logic clrBit;
        logic known;
    } dec_s;
    // Condition inputs from the datapath
    typedef struct packed {
        logic accZero;
        logic carry;
        logic bitVal;
        logic unequal;
        logic decNonzero;
    } flags_s;
    // Registered result handed to the sequencer
    typedef struct packed {
        class_e cls;
        logic [1:0] len;
        logic [3:0] cyc;
        logic taken;
        logic clrBit;
        logic extRd;
        logic extWr;
        logic extAlt;
        logic known;
    } info_s;
    typedef struct packed {
        state_e st;
        logic [3:0] cnt;
        info_s info;
        logic done;
    } state_s;
endpackage

// [xfer_branch_decode.sv]
// Decoder and cycle timer for transfer, branch and bit instructions
// Assumes opcode, flags and mode bit come from logic on clk
`timescale 1ns/1ps
`include "xfer_branch_defs.svh"
module xfer_branch_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Opcode request
    input wire logic opValid,
    input wire logic [7:0] opcode,
    output logic opReady,
    // Condition flags, external wait states, mode bit
    input wire xfer_branch_pkg::flags_s flags,
    input wire logic [2:0] extWait,
    input wire logic extModeSel,
    // Result
    output xfer_branch_pkg::info_s info,
    output logic busy,
    output logic done
);
    ////////////////////////////////////////////////////////////////////////
    // Opcode table lookup
    function automatic xfer_branch_pkg::dec_s mk(
        input xfer_branch_pkg::class_e c, input xfer_branch_pkg::cond_e k,
        input logic [1:0] l, input logic [3:0] y);
        mk = '{cls: c, cond: k, len: l, cyc: y, clrBit: 1'b0, known: 1'b1};
    endfunction

    function automatic xfer_branch_pkg::dec_s decode(input logic [7:0] op);
        decode = '{cls: xfer_branch_pkg::CLS_NONE, cond: xfer_branch_pkg::CND_NONE,
            len: `L1, cyc: `C1, clrBit: 1'b0, known: 1'b0};
        casez (op)
            // Accumulator loads
            8'b1110_1???: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L1, `C1);
            `OP_A_DIR, `OP_A_IMM: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C2);
            8'b1110_011?: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L1, `C2);
            // Register loads
            8'b1111_1???: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L1, `C2);
            8'b1010_1???: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C4);
            8'b0111_1???: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C2);
            // Direct destination stores
            `OP_DIR_A, 8'b1000_1???: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            `OP_DIR_DIR: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L3, `C4);
            8'b1000_011?: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C4);
            `OP_DIR_IMM: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L3, `C3);
            // Indirect destination stores, data pointer load and code byte loads
            8'b1111_011?: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L1, `C3);
            8'b1010_011?: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C5);
            8'b0111_011?: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            `OP_DP_IMM: decode = mk(xfer_branch_pkg::CLS_XFER,
                xfer_branch_pkg::CND_NONE, `L3, `C3);
            `OP_CODE_DP, `OP_CODE_PC: decode = mk(xfer_branch_pkg::CLS_CODE_LD,
                xfer_branch_pkg::CND_NONE, `L1, `C3);
            // External memory, base cycles before wait states; stack push and pop
            `OP_EXT_RD_DP, 8'b1110_001?: decode = mk(xfer_branch_pkg::CLS_EXT_RD,
                xfer_branch_pkg::CND_NONE, `L1, `C3);
            `OP_EXT_WR_DP, 8'b1111_001?: decode = mk(xfer_branch_pkg::CLS_EXT_WR,
                xfer_branch_pkg::CND_NONE, `L1, `C4);
            `OP_PUSH: decode = mk(xfer_branch_pkg::CLS_STACK,
                xfer_branch_pkg::CND_NONE, `L2, `C4);
            `OP_POP: decode = mk(xfer_branch_pkg::CLS_STACK,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            // Swaps with the accumulator
            8'b1100_1???: decode = mk(xfer_branch_pkg::CLS_SWAP,
                xfer_branch_pkg::CND_NONE, `L1, `C2);
            `OP_SWAP_DIR: decode = mk(xfer_branch_pkg::CLS_SWAP,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            8'b1100_011?, 8'b1101_011?: decode = mk(xfer_branch_pkg::CLS_SWAP,
                xfer_branch_pkg::CND_NONE, `L1, `C3);
            // Unconditional jumps, calls and exits
            8'b???0_0001: decode = mk(xfer_branch_pkg::CLS_JUMP,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            `OP_FAR_JUMP: decode = mk(xfer_branch_pkg::CLS_JUMP,
                xfer_branch_pkg::CND_NONE, `L3, `C4);
            `OP_REL_JUMP: decode = mk(xfer_branch_pkg::CLS_JUMP,
                xfer_branch_pkg::CND_NONE, `L2, `C3);
            `OP_JMP_IND: decode = mk(xfer_branch_pkg::CLS_JUMP,
                xfer_branch_pkg::CND_NONE, `L1, `C2);
            8'b???1_0001: decode = mk(xfer_branch_pkg::CLS_CALL,
                xfer_branch_pkg::CND_NONE, `L2, `C6);
            `OP_FAR_CALL: decode = mk(xfer_branch_pkg::CLS_CALL,
                xfer_branch_pkg::CND_NONE, `L3, `C6);
            `OP_SUB_EXIT, `OP_INT_EXIT: decode = mk(xfer_branch_pkg::CLS_EXIT,
                xfer_branch_pkg::CND_NONE, `L1, `C4);
            // Conditional branches
            `OP_BR_ZERO: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_ACC_Z, `L2, `C3);
            `OP_BR_NZERO: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_ACC_NZ, `L2, `C3);
            `OP_BR_CY: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_CY, `L2, `C3);
            `OP_BR_NCY: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_NCY, `L2, `C3);
            `OP_BR_BIT, `OP_BR_BIT_CLR: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_BIT, `L3, `C4);
            `OP_BR_NBIT: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_NBIT, `L3, `C4);
            `OP_CMP_DIR, `OP_CMP_IMM, 8'b1011_1???, 8'b1011_011?:
                decode = mk(xfer_branch_pkg::CLS_COND,
                    xfer_branch_pkg::CND_UNEQ, `L3, `C4);
            8'b1101_1???: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_DEC_NZ, `L2, `C3);
            `OP_DEC_DIR: decode = mk(xfer_branch_pkg::CLS_COND,
                xfer_branch_pkg::CND_DEC_NZ, `L3, `C4);
            // Boolean operations
            `OP_CLR_BIT, `OP_SET_BIT, `OP_INV_BIT, `OP_C_BIT:
                decode = mk(xfer_branch_pkg::CLS_BIT,
                    xfer_branch_pkg::CND_NONE, `L2, `C3);
            `OP_CLR_C, `OP_SET_C, `OP_INV_C: decode = mk(xfer_branch_pkg::CLS_BIT,
                xfer_branch_pkg::CND_NONE, `L1, `C1);
            `OP_AND_C, `OP_ANDN_C, `OP_OR_C, `OP_ORN_C, `OP_BIT_C:
                decode = mk(xfer_branch_pkg::CLS_BIT,
                    xfer_branch_pkg::CND_NONE, `L2, `C2);
            default: ;
        endcase
        // Bit test and clear also clears the tested bit
        if (op == `OP_BR_BIT_CLR)
        begin
            decode.clrBit = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and next state
    xfer_branch_pkg::state_s stateFf;
    xfer_branch_pkg::state_s nxtState;
    xfer_branch_pkg::dec_s dec;
    logic accept;
    logic taken;
    logic [3:0] cycTotal;

    // Handshake
    assign opReady = (stateFf.st == xfer_branch_pkg::ST_IDLE);
    assign accept = opValid && opReady;
    assign dec = decode(opcode);

    // Branch condition evaluation
    always_comb
    begin
        unique case (dec.cond)
            xfer_branch_pkg::CND_NONE: taken = (dec.cls != xfer_branch_pkg::CLS_NONE);
            xfer_branch_pkg::CND_ACC_Z: taken = flags.accZero;
            xfer_branch_pkg::CND_ACC_NZ: taken = !flags.accZero;
            xfer_branch_pkg::CND_CY: taken = flags.carry;
            xfer_branch_pkg::CND_NCY: taken = !flags.carry;
            xfer_branch_pkg::CND_BIT: taken = flags.bitVal;
            xfer_branch_pkg::CND_NBIT: taken = !flags.bitVal;
            xfer_branch_pkg::CND_UNEQ: taken = flags.unequal;
            xfer_branch_pkg::CND_DEC_NZ: taken = flags.decNonzero;
            default: taken = 1'b0;
        endcase
    end

    // External moves stretch by the wait states
    assign cycTotal = (dec.cls == xfer_branch_pkg::CLS_EXT_RD ||
        dec.cls == xfer_branch_pkg::CLS_EXT_WR) ?
        4'(dec.cyc + {1'b0, extWait}) : dec.cyc;

    // Sequencer
    always_comb
    begin
        nxtState = stateFf;
        nxtState.done = 1'b0;
        unique case (stateFf.st)
            xfer_branch_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    nxtState.st = xfer_branch_pkg::ST_EXEC;
                    nxtState.cnt = 4'(cycTotal - `C1);
                    nxtState.info.cls = dec.cls;
                    nxtState.info.len = dec.len;
                    nxtState.info.cyc = cycTotal;
                    nxtState.info.taken = taken;
                    nxtState.info.clrBit = dec.clrBit && flags.bitVal;
                    nxtState.info.extRd = (dec.cls == xfer_branch_pkg::CLS_EXT_RD);
                    nxtState.info.extWr = (dec.cls == xfer_branch_pkg::CLS_EXT_WR);
                    nxtState.info.extAlt = extModeSel;
                    nxtState.info.known = dec.known;
                end
            end
            xfer_branch_pkg::ST_EXEC:
            begin
                if (stateFf.cnt == `CYC_ZERO)
                begin
                    nxtState.st = xfer_branch_pkg::ST_IDLE;
                    nxtState.done = 1'b1;
                end
                else
                begin
                    nxtState.cnt = 4'(stateFf.cnt - `C1);
                end
            end
            default: nxtState.st = xfer_branch_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stateFf <= '{st: xfer_branch_pkg::ST_IDLE, cnt: '0, info: '0, done: 1'b0};
        end
        else
        begin
            stateFf <= nxtState;
        end
    end

    assign info = stateFf.info;
    assign busy = (stateFf.st == xfer_branch_pkg::ST_EXEC);
    assign done = stateFf.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    accLoad_a: assert property (
        accept && opcode == `OP_A_DIR |=> info.len == `L2 && info.cyc == `C2
        ##1 !done ##1 done) else $error("direct acc load timing wrong");
    regLoad_a: assert property (
        accept && opcode[7:3] == 5'h15 |=> info.cyc == `C4 ##1 !done[*3] ##1 done)
        else $error("register load from direct timing wrong");
    indStore_a: assert property (
        accept && opcode[7:1] == 7'h53 |=> info.len == `L2 ##1 !done[*4] ##1 done)
        else $error("indirect store from direct timing wrong");
    extRead_a: assert property (
        accept && opcode == `OP_EXT_RD_DP |=> info.extRd &&
        info.cyc == 4'(`C3 + {1'b0, $past(extWait)}))
        else $error("external read length wrong");
    extMode_a: assert property (
        accept |=> info.extAlt == $past(extModeSel))
        else $error("mode bit not captured");
    zeroBranch_a: assert property (
        accept && opcode == `OP_BR_ZERO |=> info.taken == $past(flags.accZero))
        else $error("zero branch decision wrong");
    carryBranch_a: assert property (
        accept && opcode == `OP_BR_NCY |=> info.taken != $past(flags.carry))
        else $error("no-carry branch decision wrong");
    bitClear_a: assert property (
        accept && opcode == `OP_BR_BIT_CLR && flags.bitVal |=> info.clrBit && info.len == `L3)
        else $error("tested bit not cleared");
    callTime_a: assert property (
        accept && opcode == `OP_FAR_CALL |=> busy[*6] ##1 done)
        else $error("long call timing wrong");
    carryOp_a: assert property (
        accept && opcode == `OP_SET_C |=> info.cyc == `C1 ##1 done)
        else $error("carry set timing wrong");

    // Length and cycle count per instruction group
    dirCopy_a: assert property (
        accept && opcode == `OP_DIR_DIR |=> info.len == `L3 && info.cyc == `C4)
        else $error("direct copy timing wrong");
    ptrLoad_a: assert property (
        accept && opcode == `OP_DP_IMM |=> info.len == `L3 ##1 !done[*2] ##1 done)
        else $error("pointer load timing wrong");
    codeLoad_a: assert property (
        accept && opcode == `OP_CODE_PC |=> info.cyc == `C3 &&
        info.cls == xfer_branch_pkg::CLS_CODE_LD) else $error("code load wrong");
    extWrite_a: assert property (
        accept && opcode == `OP_EXT_WR_DP |=> info.extWr &&
        info.cyc == 4'(`C4 + {1'b0, $past(extWait)})) else $error("external write wrong");
    stackPush_a: assert property (
        accept && opcode == `OP_PUSH |=> info.len == `L2 && info.cyc == `C4)
        else $error("push timing wrong");
    swapDir_a: assert property (
        accept && opcode == `OP_SWAP_DIR |=> info.cyc == `C3 &&
        info.cls == xfer_branch_pkg::CLS_SWAP) else $error("swap timing wrong");
    farJump_a: assert property (
        accept && opcode == `OP_FAR_JUMP |=> info.len == `L3 && info.cyc == `C4 && info.taken)
        else $error("long jump timing wrong");
    cmpBranch_a: assert property (
        accept && opcode == `OP_CMP_IMM |=> info.cyc == `C4 &&
        info.taken == $past(flags.unequal)) else $error("compare branch wrong");
    decBranch_a: assert property (
        accept && opcode[7:3] == 5'h1B |=> info.cyc == `C3 &&
        info.taken == $past(flags.decNonzero)) else $error("decrement branch wrong");
    carryOr_a: assert property (
        accept && opcode == `OP_OR_C |=> info.len == `L2 && info.cyc == `C2)
        else $error("carry combine timing wrong");
    carryStore_a: assert property (
        accept && opcode == `OP_C_BIT |=> info.len == `L2 && info.cyc == `C3)
        else $error("carry to bit timing wrong");
    subExit_a: assert property (
        accept && opcode == `OP_SUB_EXIT |=> info.cyc == `C4 &&
        info.cls == xfer_branch_pkg::CLS_EXIT) else $error("return timing wrong");
    unknownOp_a: assert property (
        accept && !dec.known |=> !info.known && !info.taken && info.cyc == `C1)
        else $error("unknown opcode not refused");

    extWaitMax_c: cover property (accept && opcode == `OP_EXT_WR_DP && extWait == 3'h7);
    zeroTaken_c: cover property (accept && opcode == `OP_BR_ZERO && flags.accZero);
    backToBack_c: cover property (done ##0 accept);
    condSkip_c: cover property (accept && dec.cls == xfer_branch_pkg::CLS_COND && !taken);
    unknownOp_c: cover property (accept && !dec.known);
endmodule

// [prog_mem_model.sv]
// Program and external memory model feeding opcodes to the decoder
// Assumes the bench asks for one opcode at a time through load
`timescale 1ns/1ps
module prog_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench requests
    input wire logic load,
    input wire logic [7:0] nextOp,
    input wire logic [2:0] slowness,
    // Decoder side
    input wire logic opReady,
    output logic opValid,
    output logic [7:0] opcode,
    output logic [2:0] extWait
);
    ////////////////////////////////////////////////////////////////////////////////
    // Hold each opcode until taken; released lines change every cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            opValid <= 1'h0;
            opcode <= 8'h5A;
            extWait <= 3'h5;
        end
        else if (load)
        begin
            opValid <= 1'h1;
            opcode <= nextOp;
            extWait <= slowness;
        end
        else if (!opValid || opReady)
        begin
            opValid <= 1'h0;
            opcode <= ~opcode;
            extWait <= ~extWait;
        end
    end
endmodule

// [test_cpu_transfer_branch_bit_decode.sv]
// Self-checking bench for the transfer, branch and bit decoder
// Assumes the decoder package and the program memory model
`timescale 1ns/1ps
module test_cpu_transfer_branch_bit_decode;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic load = 1'h0;
    logic [7:0] nextOp = 8'h00;
    logic [2:0] slowness = 3'h0;
    logic opValid;
    logic [7:0] opcode;
    logic opReady;
    xfer_branch_pkg::flags_s flags = '0;
    logic [2:0] extWait;
    logic extModeSel = 1'h0;
    xfer_branch_pkg::info_s info;
    logic busy;
    logic done;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Unconditional ops: opcode, bytes, cycles
    localparam logic [15:0] UNCOND [59] = '{
        16'hE811, 16'hEF11, 16'hE522, 16'hE612, 16'hE712, 16'h7422,
        16'hF812, 16'hFF12, 16'hA824, 16'hAF24, 16'h7822, 16'h7F22,
        16'hF523, 16'h8823, 16'h8F23, 16'h8534, 16'h8624, 16'h8724, 16'h7533,
        16'hF613, 16'hF713, 16'hA625, 16'hA725, 16'h7623, 16'h7723,
        16'h9033, 16'h9313, 16'h8313, 16'hC024, 16'hD023,
        16'hC812, 16'hCF12, 16'hC523, 16'hC613, 16'hC713, 16'hD613, 16'hD713,
        16'h0123, 16'hE123, 16'h0234, 16'h8023, 16'h7312,
        16'hC223, 16'hD223, 16'hB223, 16'hC311, 16'hD311, 16'hB311,
        16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222, 16'h9223,
        16'h1126, 16'hF126, 16'h1236, 16'h2214, 16'h3214};
    // Branches: opcode, bytes, cycles, flag bit, level that takes it
    localparam logic [23:0] COND [16] = '{
        24'h602341, 24'h702340, 24'h402331, 24'h502330,
        24'h203421, 24'h303420, 24'h103421,
        24'hB53411, 24'hB43411, 24'hB83411, 24'hBF3411, 24'hB63411, 24'hB73411,
        24'hD82301, 24'hDF2301, 24'hD53401};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, partner and design
    always #10 clk = ~clk;
    prog_mem_model mem (.clk(clk), .nrst(nrst), .load(load), .nextOp(nextOp),
        .slowness(slowness), .opReady(opReady), .opValid(opValid), .opcode(opcode),
        .extWait(extWait));
    xfer_branch_decode uut (.clk(clk), .nrst(nrst), .opValid(opValid), .opcode(opcode),
        .opReady(opReady), .flags(flags), .extWait(extWait), .extModeSel(extModeSel),
        .info(info), .busy(busy), .done(done));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, verdict and hang guard
    task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared steps
    task automatic wait_accept(output int k);
        k = 0;
        while (!(opValid === 1'h1 && opReady === 1'h1) && k < 64)
        begin
            @(posedge clk);
            k++;
        end
        cmp("accept wait", 16'h0000, {15'h0000, k >= 64});
    endtask
    task automatic check_idle;
        cmp("idle lines", 16'h0001, {13'h0000, busy, done, opReady});
        cmp("info", 16'h0000, info);
    endtask
    task automatic run_op(input logic [7:0] op, input xfer_branch_pkg::flags_s f,
        input logic [2:0] w, input logic m, input logic [1:0] eLen,
        input logic [3:0] eCyc, input logic [5:0] eBits);
        int k;
        logic early;
        early = 1'h0;
        @(posedge clk);
        load <= 1'h1;
        nextOp <= op;
        slowness <= w;
        flags <= f;
        extModeSel <= m;
        @(posedge clk);
        load <= 1'h0;
        wait_accept(k);
        @(negedge clk);
        cmp("len", {14'h0000, eLen}, {14'h0000, info.len});
        cmp("cyc", {12'h000, eCyc}, {12'h000, info.cyc});
        cmp("result bits", {10'h000, eBits}, {10'h000, info.taken, info.clrBit,
            info.extRd, info.extWr, info.extAlt, info.known});
        cmp("busy", 16'h0001, {15'h0000, busy});
        for (int n = 1; n < eCyc; n++)
        begin
            @(negedge clk);
            early = early | done;
        end
        @(negedge clk);
        cmp("early done", 16'h0000, {15'h0000, early});
        cmp("finish", 16'h0005, {13'h0000, done, busy, opReady});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic uncond_op(input int i);
        run_op(UNCOND[i][15:8], '0, 3'h0, 1'h0, UNCOND[i][5:4], UNCOND[i][3:0], 6'h21);
    endtask
    task automatic test_uncond;
        for (int i = 0; i < 30; i++)
            uncond_op(i);
        for (int i = 30; i < 59; i++)
            uncond_op(i);
        run_op(8'hA5, '0, 3'h0, 1'h0, 2'h1, 4'h1, 6'h00);
        $display("test unconditional ops finished");
    endtask
    task automatic test_cond;
        logic [23:0] e;
        logic [4:0] fb;
        logic t;
        logic clr;
        for (int i = 0; i < 16; i++)
            for (int v = 0; v < 2; v++)
            begin
                e = COND[i];
                fb = 5'h01 << e[7:4];
                t = (v[0] == e[0]);
                clr = (e[23:16] == 8'h10) && (v == 1);
                run_op(e[23:16], xfer_branch_pkg::flags_s'((v == 1) ? fb : ~fb), 3'h0, 1'h0,
                    e[13:12], e[11:8], {t, clr, 4'h1});
            end
        $display("test conditional branches finished");
    endtask
    task automatic test_external;
        logic [7:0] ops [6] = '{8'hE2, 8'hE3, 8'hE0, 8'hF2, 8'hF3, 8'hF0};
        logic [2:0] w;
        logic rd;
        for (int i = 0; i < 6; i++)
            for (int j = 0; j < 2; j++)
            begin
                w = (j == 1) ? 3'h7 : 3'h0;
                rd = (i < 3);
                run_op(ops[i], '0, w, (j == 0), 2'h1, {1'h0, w} + (rd ? 4'h3 : 4'h4),
                    {2'h2, rd, !rd, (j == 0), 1'h1});
            end
        $display("test external moves finished");
    endtask
    task automatic test_back_to_back;
        int k;
        @(posedge clk);
        load <= 1'h1;
        nextOp <= 8'hE5;
        @(posedge clk);
        load <= 1'h0;
        wait_accept(k);
        load <= 1'h1;
        nextOp <= 8'h90;
        @(posedge clk);
        load <= 1'h0;
        @(negedge clk);
        cmp("len while busy", 16'h0002, {14'h0000, info.len});
        wait_accept(k);
        cmp("accept spacing", 16'h0002, k[15:0]);
        @(negedge clk);
        cmp("second len", 16'h0003, {14'h0000, info.len});
        repeat (3) @(negedge clk);
        cmp("second done", 16'h0001, {15'h0000, done});
        $display("test back to back finished");
    endtask
    task automatic test_mid_reset;
        int k;
        @(posedge clk);
        load <= 1'h1;
        nextOp <= 8'hA6;
        @(posedge clk);
        load <= 1'h0;
        wait_accept(k);
        @(posedge clk);
        nrst <= 1'h0;
        @(negedge clk);
        check_idle();
        @(posedge clk);
        nrst <= 1'h1;
        @(negedge clk);
        check_idle();
        $display("test reset in mid operation finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (9) @(posedge clk);
        @(negedge clk);
        check_idle();
        @(posedge clk);
        nrst <= 1'h1;
        @(negedge clk);
        check_idle();
        test_uncond();
        test_cond();
        test_external();
        test_back_to_back();
        test_mid_reset();
        report_and_stop();
    end
endmodule
